// *** common/can_diag_defs.svh ***
// Purpose: offsets, field positions, reset values for error state and diagnostics
// Assumes: register port with byte offsets
// Notes:   definitions only
`ifndef CAN_DIAG_DEFS_SVH
`define CAN_DIAG_DEFS_SVH

// ==========================================
// register offsets
`define OFS_ERROR_STATE_COUNTS  4'h0
`define OFS_BUS_DIAG_COUNTS     4'h4
`define OFS_BUS_DIAG_FLAGS      4'h8
`define OFS_DIAG_CONTROL        4'hC

// ==========================================
// error count register fields
`define POS_BUS_OFF             21
`define POS_TX_PASSIVE          20
`define POS_RX_PASSIVE          19
`define POS_TX_WARNING          18
`define POS_RX_WARNING          17
`define POS_ANY_WARNING         16

// ==========================================
// error thresholds
`define LIM_WARNING_LOW         9'h05F
`define LIM_PASSIVE             9'h07F
`define LIM_BUS_OFF             9'h0FF

// ==========================================
// diagnostic flag positions
`define POS_LENGTH_MISMATCH     31
`define POS_ESI_SEEN            30
`define POS_BUS_OFF_EVENT       23
`define MASK_DIAG_FLAGS         16'hFBBF

// ==========================================
// reset values
`define RST_ZERO32              32'h0000_0000
`define RST_CONTROL             32'h0000_0001

`endif

// *** common/can_diag_pkg.sv ***
// Purpose: types for the error state and diagnostic block
// Assumes: nothing
// Notes:   error event group travels as one struct
package can_diag_pkg;

  // ==========================================
  // one error event per kind from the protocol engine
  typedef struct packed {
    logic crc;
    logic stuff;
    logic form;
    logic ack;
    logic recessive;
    logic dominant;
  } err_event_type;

  typedef enum logic [1:0] {
    st_config  = 2'b00,
    st_active  = 2'b01,
    st_bus_off = 2'b10
  } node_state_type;

endpackage : can_diag_pkg

// *** logic/can_error_state_diag.sv ***
// Purpose: error confinement status and bus diagnostic registers
// Assumes: protocol engine supplies counters and one-cycle error events on clk_sys
// Notes:   register port, read data one cycle after read strobe
// Functional notes
// [RULE_01] bus-off flag when transmit count above 255
// [RULE_02] bus-off reads set in configuration mode
// [RULE_03] transmit passive when count above 127
// [RULE_04] receive passive when count above 127
// [RULE_05] transmit warning for count 96 to 127
// [RULE_06] receive warning for count 96 to 127
// [RULE_07] combined warning from either warning flag
// [RULE_08] counts in bytes one and zero, read-only
// [RULE_09] data phase counters in top two bytes
// [RULE_10] nominal counters in lower two bytes
// [RULE_11] length mismatch when code exceeds payload size
// [RULE_12] flag received frames with error state indicator
// [RULE_13] data phase crc, stuff, form, bit flags
// [RULE_14] bus-off event after automatic recovery
// [RULE_15] nominal crc mismatch flag
// [RULE_16] nominal stuff violation flag
// [RULE_17] nominal form violation flag
// [RULE_18] missing acknowledge flag
// [RULE_19] recessive sent, dominant seen flag
// [RULE_20] dominant sent, recessive seen flag
// [RULE_21] sixteen bit error-free message counter
// [RULE_22] unused bits read as zero
// [RULE_23] flags sticky until software writes zero
// [RULE_24] state flags combinational from counters
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "can_diag_defs.svh"
module can_error_state_diag
  import can_diag_pkg::*;
#(
  parameter int ADDR_WIDTH = 4
)(
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [31:0]           reg_rdata,
  // protocol engine side
  input  wire logic [8:0]            transmit_error_count,
  input  wire logic [7:0]            receive_error_count,
  input  wire logic                  config_mode,
  input  wire err_event_type         nominal_err,
  input  wire err_event_type         data_phase_err,
  input  wire logic                  frame_tx_done,
  input  wire logic                  frame_rx_done,
  input  wire logic                  frame_is_tx,
  input  wire logic [3:0]            frame_dlc,
  input  wire logic [2:0]            payload_size,
  input  wire logic                  esi_received,
  input  wire logic                  bus_off_recovered,
  // status outputs
  output logic                       bus_off_flag,
  output logic                       any_warning_flag
);

  // ==========================================
  // state flags
  logic [5:0] state_flags;
  logic [8:0] rx_count_wide;

  assign rx_count_wide = {1'b0, receive_error_count};

  err_count_flags u_flags (
    .tx_count    (transmit_error_count),
    .rx_count    (rx_count_wide),
    .config_mode (config_mode),
    .state_flags (state_flags)
  );

  // status pins straight from flags
  assign bus_off_flag     = state_flags[5];   // RULE_01 RULE_02
  assign any_warning_flag = state_flags[0];   // RULE_07

  // ==========================================
  // register decode
  logic wr_counts;
  logic wr_flags;
  logic wr_ctrl;

  assign wr_counts = reg_write && (reg_addr == `OFS_BUS_DIAG_COUNTS);
  assign wr_flags  = reg_write && (reg_addr == `OFS_BUS_DIAG_FLAGS);
  assign wr_ctrl   = reg_write && (reg_addr == `OFS_DIAG_CONTROL);

  // ==========================================
  // control: bit 0 enables diagnostic counting
  logic [31:0] control_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      control_reg <= `RST_CONTROL;
    end else if (wr_ctrl) begin
      control_reg <= {31'h0000_0000, reg_wdata[0]};
    end
  end

  logic count_en;
  assign count_en = control_reg[0];

  // ==========================================
  // phase error counters, saturating
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
    sat_inc = (hit && v != 8'hFF) ? v + 8'h01 : v;
  endfunction : sat_inc

  logic nom_tx_hit;
  logic nom_rx_hit;
  logic dat_tx_hit;
  logic dat_rx_hit;

  // transmit side errors are bit and nominal ack, receive side crc, stuff and form
  assign nom_tx_hit = count_en & (nominal_err.ack | nominal_err.recessive |
                                  nominal_err.dominant);
  assign nom_rx_hit = count_en & (nominal_err.crc | nominal_err.stuff | nominal_err.form);
  assign dat_tx_hit = count_en & (data_phase_err.recessive | data_phase_err.dominant);
  assign dat_rx_hit = count_en & (data_phase_err.crc | data_phase_err.stuff |
                                  data_phase_err.form);

  logic [31:0] counts_reg;

  // hardware increment applies on top of a software write
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      counts_reg <= `RST_ZERO32;
    end else begin
      counts_reg[31:24] <= sat_inc(wr_counts ? reg_wdata[31:24] : counts_reg[31:24],
                                   dat_tx_hit);   // RULE_09
      counts_reg[23:16] <= sat_inc(wr_counts ? reg_wdata[23:16] : counts_reg[23:16],
                                   dat_rx_hit);   // RULE_09
      counts_reg[15:8]  <= sat_inc(wr_counts ? reg_wdata[15:8] : counts_reg[15:8],
                                   nom_tx_hit);   // RULE_10
      counts_reg[7:0]   <= sat_inc(wr_counts ? reg_wdata[7:0] : counts_reg[7:0],
                                   nom_rx_hit);   // RULE_10
    end
  end

  // ==========================================
  // sticky error flags
  logic [15:0] flag_set;
  logic [15:0] flags_reg;
  logic        len_mismatch;

  // payload code to largest fitting dlc code, compared in dlc terms
  function automatic logic [3:0] size_to_dlc(input logic [2:0] ps);
    case (ps)
      3'd0:    size_to_dlc = 4'd8;
      3'd1:    size_to_dlc = 4'd9;
      3'd2:    size_to_dlc = 4'd10;
      3'd3:    size_to_dlc = 4'd11;
      3'd4:    size_to_dlc = 4'd12;
      3'd5:    size_to_dlc = 4'd13;
      3'd6:    size_to_dlc = 4'd14;
      default: size_to_dlc = 4'd15;
    endcase
  endfunction : size_to_dlc

  assign len_mismatch = (frame_tx_done | frame_rx_done) &&
                        (frame_dlc > size_to_dlc(payload_size));   // RULE_11

  always_comb begin
    flag_set     = 16'h0000;
    flag_set[15] = len_mismatch;                        // RULE_11
    flag_set[14] = esi_received;                        // RULE_12
    flag_set[13] = data_phase_err.crc;                  // RULE_13
    flag_set[12] = data_phase_err.stuff;                // RULE_13
    flag_set[11] = data_phase_err.form;                 // RULE_13
    flag_set[9]  = data_phase_err.recessive;            // RULE_13
    flag_set[8]  = data_phase_err.dominant;             // RULE_13
    flag_set[7]  = bus_off_recovered;                   // RULE_14
    flag_set[5]  = nominal_err.crc;                     // RULE_15
    flag_set[4]  = nominal_err.stuff;                   // RULE_16
    flag_set[3]  = nominal_err.form;                    // RULE_17
    flag_set[2]  = nominal_err.ack;                     // RULE_18
    flag_set[1]  = nominal_err.recessive;               // RULE_19
    flag_set[0]  = nominal_err.dominant;                // RULE_20
  end

  // set beats clear; writing zero clears, one keeps
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      flags_reg <= 16'h0000;
    end else begin
      flags_reg <= (wr_flags ? (flags_reg & reg_wdata[31:16]) : flags_reg)
                   | flag_set;                                       // RULE_23
    end
  end

  // ==========================================
  // error-free message counter
  logic [15:0] clean_message_count;
  logic        frame_clean;

  assign frame_clean = (frame_tx_done | frame_rx_done) &&
                       !(|nominal_err) && !(|data_phase_err);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clean_message_count <= 16'h0000;
    end else if (frame_clean && count_en) begin
      clean_message_count <= clean_message_count + 16'h0001;   // RULE_21
    end else if (wr_flags) begin
      clean_message_count <= reg_wdata[15:0];
    end
  end

  // ==========================================
  // read data, one cycle after strobe
  logic [31:0] rdata_next;

  always_comb begin
    case (reg_addr)
      `OFS_ERROR_STATE_COUNTS:
        rdata_next = {10'h000, state_flags,                          // RULE_22
                      transmit_error_count[7:0], receive_error_count};   // RULE_08
      `OFS_BUS_DIAG_COUNTS: rdata_next = counts_reg;                 // RULE_09 RULE_10
      `OFS_BUS_DIAG_FLAGS:
        rdata_next = {flags_reg & `MASK_DIAG_FLAGS, clean_message_count};   // RULE_22
      `OFS_DIAG_CONTROL:    rdata_next = control_reg;
      default:              rdata_next = `RST_ZERO32;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= `RST_ZERO32;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `RST_ZERO32;
    end
  end

endmodule : can_error_state_diag

// *** logic/err_count_flags.sv ***
// Purpose: derive confinement state flags from error counters
// Assumes: counters are nine bits so bus-off is above 255
// Notes:   purely combinational
`timescale 1ns/1ns
`include "can_diag_defs.svh"
module err_count_flags
  import can_diag_pkg::*;
(
  input  wire logic [8:0] tx_count,
  input  wire logic [8:0] rx_count,
  input  wire logic       config_mode,
  output logic      [5:0] state_flags
);

  // ==========================================
  // warning band test shared by both counters
  function automatic logic in_warning(input logic [8:0] cnt);
    in_warning = (cnt > `LIM_WARNING_LOW) && (cnt <= `LIM_PASSIVE);
  endfunction : in_warning

  // flags follow counters with no delay
  always_comb begin                                                   // RULE_24
    state_flags[5] = (tx_count > `LIM_BUS_OFF) | config_mode;         // RULE_01 RULE_02
    state_flags[4] = tx_count > `LIM_PASSIVE;                         // RULE_03
    state_flags[3] = rx_count > `LIM_PASSIVE;                         // RULE_04
    state_flags[2] = in_warning(tx_count);                            // RULE_05
    state_flags[1] = in_warning(rx_count);                            // RULE_06
    state_flags[0] = in_warning(tx_count) | in_warning(rx_count);     // RULE_07
  end

endmodule : err_count_flags

// *** verification/can_diag_checker_assertions.sv ***
// Purpose: port checks for error state and diagnostics
// Assumes: read data stands only in the cycle after the strobe
// Notes:   bound to the top module
`timescale 1ns/1ns
module can_diag_checker
  import can_diag_pkg::*;
#(
  parameter int ADDR_WIDTH = 4
)(
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic                  reg_read,
  input wire logic [31:0]           reg_rdata,
  input wire logic [8:0]            transmit_error_count,
  input wire logic [7:0]            receive_error_count,
  input wire logic                  config_mode,
  input wire err_event_type         nominal_err,
  input wire logic                  esi_received,
  input wire logic                  bus_off_flag,
  input wire logic                  any_warning_flag
);
  // ====
  // warning windows of both counters
  wire logic tw;
  wire logic rw;
  assign tw = transmit_error_count > 9'h05F && transmit_error_count < 9'h080;
  assign rw = receive_error_count > 8'h5F && receive_error_count < 8'h80;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  bus_off_pin_a: assert property (bus_off_flag == (transmit_error_count[8] | config_mode))
    else $error("bus-off pin wrong");
  warning_pin_a: assert property (any_warning_flag == (tw | rw))
    else $error("warning pin wrong");
  state_read_a: assert property ($past(reg_read) && $past(reg_addr) == 4'h0 |->
    reg_rdata == {10'h000, $past(bus_off_flag), $past(transmit_error_count) > 9'h07F,
    $past(receive_error_count) > 8'h7F, $past(tw), $past(rw), $past(any_warning_flag),
    $past(transmit_error_count[7:0]), $past(receive_error_count)}) else $error("state word");
  nominal_flag_a: assert property (nominal_err != 6'h00 ##1 reg_read && reg_addr == 4'h8
    |=> (reg_rdata[21:16] & $past(nominal_err, 2)) == $past(nominal_err, 2))
    else $error("nominal flag missing");
  esi_flag_a: assert property (esi_received ##1 reg_read && reg_addr == 4'h8
    |=> reg_rdata[30]) else $error("esi flag missing");
  reserved_zero_a: assert property ($past(reg_read) && $past(reg_addr) == 4'h8
    |-> reg_rdata[26] == 1'b0 && reg_rdata[22] == 1'b0) else $error("reserved bit set");
  unmapped_zero_a: assert property ($past(reg_read) && $past(reg_addr[1:0]) != 2'h0
    |-> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule : can_diag_checker

bind can_error_state_diag can_diag_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk_sys,
  .reset_n, .reg_addr, .reg_read, .reg_rdata, .transmit_error_count, .receive_error_count,
  .config_mode, .nominal_err, .esi_received, .bus_off_flag, .any_warning_flag);

// *** verification/can_error_state_diag_tb.sv ***
// Purpose: register test of error state and diagnostics
// Assumes: engine stand-in drives the protocol side
// Notes:   expected words built from field positions
`timescale 1ns/1ns
module can_error_state_diag_tb
  import can_diag_pkg::*;
;
  logic clk_sys, reset_n, reg_write, reg_read, frame_tx_done, frame_rx_done, frame_is_tx;
  logic config_mode, esi_received, bus_off_recovered, bus_off_flag, any_warning_flag;
  logic [3:0]    reg_addr, frame_dlc;
  logic [31:0]   reg_wdata, reg_rdata, d, e, ef;
  logic [8:0]    transmit_error_count;
  logic [7:0]    receive_error_count;
  logic [2:0]    payload_size;
  err_event_type nominal_err, data_phase_err;
  int            miscompares, comparisons;
  logic [8:0]    tt [7] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h000};
  logic [7:0]    rt [7] = '{8'h60, 8'h7F, 8'h80, 8'h5F, 8'h00, 8'hC8, 8'h00};
  // ====
  // device and engine
  can_error_state_diag #(.ADDR_WIDTH(4)) dut_u (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .transmit_error_count, .receive_error_count,
    .config_mode, .nominal_err, .data_phase_err, .frame_tx_done, .frame_rx_done,
    .frame_is_tx, .frame_dlc, .payload_size, .esi_received, .bus_off_recovered,
    .bus_off_flag, .any_warning_flag);
  engine_model eng_u (.clk_sys, .transmit_error_count, .receive_error_count, .config_mode,
    .nominal_err, .data_phase_err, .frame_tx_done, .frame_rx_done, .frame_is_tx,
    .frame_dlc, .payload_size, .esi_received, .bus_off_recovered);
  // ====
  // bus tasks and compare
  task automatic chk(input string w, input logic [31:0] s, x);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", w, x, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  function automatic logic [31:0] st(input logic [8:0] t, input logic [7:0] r, input logic c);
    logic tw, rw;
    tw = t > 9'h05F && t < 9'h080;
    rw = r > 8'h5F && r < 8'h80;
    return {10'h000, t[8] | c, t > 9'h07F, r > 8'h7F, tw, rw, tw | rw, t[7:0], r};
  endfunction : st
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // ====
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
  // ====
  // main sequence
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata, ef} = '0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h8);
    chk("flags reset", d, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      eng_u.levels(tt[i], rt[i], i == 6);
      e = st(tt[i], rt[i], i == 6);
      rd(4'h0);
      chk("state word", d, e);
      chk("bus-off pin", bus_off_flag, e[21]);
      chk("warning pin", any_warning_flag, e[16]);
    end
    wr(4'h0, 32'hFFFF_FFFF);
    rd(4'h0);
    chk("read-only word", d, e);
    rd(4'h2);
    chk("unmapped", d, 32'h0000_0000);
    eng_u.levels(9'h000, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      eng_u.pulse(err_event_type'(6'h01 << i), '0, 5'h00, 4'h0, 3'h0);
      ef[16 + i] = 1'b1;
      rd(4'h8);
      chk("nominal flags", d, ef);
    end
    for (int i = 0; i < 6; i++) begin
      if (i == 2) continue;
      eng_u.pulse('0, err_event_type'(6'h01 << i), 5'h00, 4'h0, 3'h0);
      ef[24 + i] = 1'b1;
      rd(4'h8);
      chk("data flags", d, ef);
    end
    rd(4'h4);
    chk("phase counts", d, 32'h0203_0303);
    eng_u.pulse('0, '0, 5'h10, 4'h0, 3'h0);
    ef[30] = 1'b1;
    rd(4'h8);
    chk("esi flag", d, ef);
    eng_u.pulse('0, '0, 5'h08, 4'h0, 3'h0);
    ef[23] = 1'b1;
    rd(4'h8);
    chk("bus-off event", d, ef);
    wr(4'h8, 32'hFF00_0000);
    rd(4'h8);
    chk("partial clear", d, ef & 32'hFF00_0000);
    wr(4'h8, 32'h0000_0000);
    eng_u.pulse('0, '0, 5'h02, 4'hF, 3'h7);
    rd(4'h8);
    chk("length fits", d[31], 1'b0);
    eng_u.pulse('0, '0, 5'h05, 4'h9, 3'h0);
    rd(4'h8);
    chk("length mismatch", d[31], 1'b1);
    wr(4'h8, 32'h0000_1234);
    eng_u.pulse('0, '0, 5'h02, 4'h8, 3'h0);
    rd(4'h8);
    chk("clean count", d, 32'h0000_1235);
    eng_u.pulse(err_event_type'(6'h20), '0, 5'h05, 4'h8, 3'h0);
    rd(4'h8);
    chk("errored frame", d, 32'h0020_1235);
    wr(4'h4, 32'h0000_00FE);
    for (int i = 0; i < 2; i++) begin
      eng_u.pulse(err_event_type'(6'h08), '0, 5'h00, 4'h0, 3'h0);
      rd(4'h4);
    end
    chk("rx count cap", d, 32'h0000_00FF);
    wr(4'hC, 32'h0000_0000);
    eng_u.pulse(err_event_type'(6'h04), '0, 5'h00, 4'h0, 3'h0);
    rd(4'h4);
    chk("counting held", d, 32'h0000_00FF);
    summarize();
  end
endmodule : can_error_state_diag_tb

// *** verification/engine_model.sv ***
// Purpose: protocol engine stand-in for counters and events
// Assumes: tasks entered just after a clock edge
// Notes:   idle frame code shows the inverse of the last one
`timescale 1ns/1ns
module engine_model
  import can_diag_pkg::*;
(
  input  wire logic    clk_sys,
  output logic [8:0]   transmit_error_count,
  output logic [7:0]   receive_error_count,
  output logic         config_mode,
  output err_event_type nominal_err,
  output err_event_type data_phase_err,
  output logic         frame_tx_done,
  output logic         frame_rx_done,
  output logic         frame_is_tx,
  output logic [3:0]   frame_dlc,
  output logic [2:0]   payload_size,
  output logic         esi_received,
  output logic         bus_off_recovered
);
  // ====
  // quiet engine at time zero
  initial begin
    {transmit_error_count, receive_error_count, config_mode, nominal_err} = '0;
    {data_phase_err, frame_tx_done, frame_rx_done, frame_is_tx, frame_dlc} = '0;
    {payload_size, esi_received, bus_off_recovered} = '0;
  end
  // counter levels and mode
  task automatic levels(input logic [8:0] t, input logic [7:0] r, input logic c);
    transmit_error_count <= t;
    receive_error_count <= r;
    config_mode <= c;
    @(posedge clk_sys);
  endtask : levels
  // one-cycle pulses: misc is esi, recovered, tx done, rx done, is tx
  task automatic pulse(input err_event_type n, dp, input logic [4:0] m,
                       input logic [3:0] dlc, input logic [2:0] psz);
    {nominal_err, data_phase_err} <= {n, dp};
    {esi_received, bus_off_recovered, frame_tx_done, frame_rx_done, frame_is_tx} <= m;
    frame_dlc <= dlc;
    payload_size <= psz;
    @(posedge clk_sys);
    {nominal_err, data_phase_err} <= '0;
    {esi_received, bus_off_recovered, frame_tx_done, frame_rx_done, frame_is_tx} <= '0;
    frame_dlc <= ~dlc;
  endtask : pulse
endmodule : engine_model
